// File: scrx_pkg.sv
// Package of constants and types for the serial channel receiver
package scrx_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [1:0] SCRX_ADDR_BUF = 2'h0;
  localparam logic [1:0] SCRX_ADDR_CR = 2'h1;
  localparam logic [1:0] SCRX_ADDR_MOD = 2'h2;
  localparam logic [1:0] SCRX_ADDR_IRQ = 2'h3;
  // Mode register fields
  localparam int SCRX_MOD_SM_LO = 0;
  localparam int SCRX_MOD_RXE = 5;
  localparam int SCRX_MOD_WU = 4;
  localparam int SCRX_MOD_TB8 = 7;
  // Control register fields
  localparam int SCRX_CR_IOC = 0;
  localparam int SCRX_CR_SCLKS = 1;
  localparam int SCRX_CR_FRAMING_FLAG = 2;
  localparam int SCRX_CR_PARITY_ERROR_FLAG = 3;
  localparam int SCRX_CR_OVERRUN_FLAG = 4;
  localparam int SCRX_CR_PE = 5;
  localparam int SCRX_CR_EVEN = 6;
  localparam int SCRX_CR_RB8 = 7;
  // Reset values
  localparam logic [7:0] SCRX_MOD_RST = 8'h00;
  localparam logic [7:0] SCRX_CR_RST = 8'h00;
  // Frame modes
  localparam logic [1:0] SCRX_SM_IO = 2'h0;
  localparam logic [1:0] SCRX_SM_7B = 2'h1;
  localparam logic [1:0] SCRX_SM_8B = 2'h2;
  localparam logic [1:0] SCRX_SM_9B = 2'h3;
  // Timing
  localparam int SCRX_CLK_HZ = 25_000_000;
  localparam int SCRX_OVS = 16;
  localparam logic [3:0] SCRX_MID = 4'h7;
  localparam logic [7:0] SCRX_SCLK_HALF = 8'h04;
  localparam logic [15:0] SCRX_BAUD_DIV_RST = 16'h00_0c;
  typedef enum logic [2:0] {
    SCRX_IDLE,
    SCRX_START,
    SCRX_DATA,
    SCRX_STOP,
    SCRX_SHIFT
  } scrx_state_e;
endpackage

// File: scrx_tick.sv
// Enable pulse divider for the serial channel receiver
`timescale 1ns/1ps
`default_nettype none
module scrx_tick
  import scrx_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] div_in,
  output logic tick_out
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 16'h0001;
    if (cnt_r >= div_in) begin
      cnt_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= 16'h0000;
      tick_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_out <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// File: scrx_top.sv
// Receive side of one serial channel: shift mode and asynchronous frames
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module scrx_top
  import scrx_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic serial_in_pin_in,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe_out,
  output logic rx_interrupt_out,
  output logic [7:0] mode_out
);
  // ****************************************************
  // Registers
  // ****************************************************
  logic [7:0] mod_r, mod_nxt;
  logic [7:0] cr_r, cr_nxt;
  logic [7:0] buf_r, buf_nxt;
  logic [15:0] div_r, div_nxt;
  logic [7:0] rdata_nxt;
  logic pend_r, pend_nxt;
  logic full_r, full_nxt;
  logic irq_nxt;
  scrx_state_e st_r, st_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [3:0] ph_r, ph_nxt;
  logic [2:0] smp_r, smp_nxt;
  logic [7:0] sc_r, sc_nxt;
  logic sclk_r, sclk_nxt;
  logic ext_d_r;
  logic tick;

  scrx_tick u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .div_in(div_r),
    .tick_out(tick)
  );

  function automatic logic [3:0] frame_bits(input logic [1:0] sm,
                                            input logic pe);
    case (sm)
      SCRX_SM_7B: frame_bits = pe ? 4'h8 : 4'h7;
      SCRX_SM_8B: frame_bits = pe ? 4'h9 : 4'h8;
      default: frame_bits = 4'h9;
    endcase
  endfunction

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  logic [1:0] sm;
  logic receive_enable_bit, pe, even, wu, ioc, sclks;
  logic buf_rd;
  logic ext_edge;
  logic [3:0] nbits;
  // Frame completion and accept decision, visible to the checks below
  logic done;
  logic raise;
  assign sm = mod_r[SCRX_MOD_SM_LO +: 2];
  assign receive_enable_bit = mod_r[SCRX_MOD_RXE];
  assign wu = mod_r[SCRX_MOD_WU];
  assign pe = cr_r[SCRX_CR_PE] && (sm != SCRX_SM_9B);
  assign even = cr_r[SCRX_CR_EVEN];
  assign ioc = cr_r[SCRX_CR_IOC];
  assign sclks = cr_r[SCRX_CR_SCLKS];
  assign buf_rd = rd_in && (addr_in == SCRX_ADDR_BUF);
  assign nbits = frame_bits(sm, pe);
  // Pins taken as synchronous; rising or falling per edge select
  assign ext_edge = sclks ? (ext_d_r && !shift_clock_pin_in)
                          : (!ext_d_r && shift_clock_pin_in);

  // ****************************************************
  // Receiver and register next state
  // ****************************************************
  always_comb begin
    logic [8:0] fr;
    logic [7:0] dat;
    logic nin, parity_error_flag, fer, par;
    done = 1'b0;
    fr = 9'h000;
    dat = 8'h00;
    nin = 1'b0;
    parity_error_flag = 1'b0;
    fer = 1'b0;
    par = 1'b0;
    raise = 1'b0;
    mod_nxt = mod_r;
    cr_nxt = cr_r;
    buf_nxt = buf_r;
    div_nxt = div_r;
    pend_nxt = pend_r;
    full_nxt = full_r;
    st_nxt = st_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    ph_nxt = ph_r;
    smp_nxt = smp_r;
    sc_nxt = sc_r;
    sclk_nxt = sclk_r;
    rdata_nxt = 8'h00;
    if (rd_in) begin
      case (addr_in)
        SCRX_ADDR_BUF: rdata_nxt = buf_r;
        SCRX_ADDR_CR: rdata_nxt = cr_r;
        SCRX_ADDR_MOD: rdata_nxt = mod_r;
        default: rdata_nxt = {7'h00, pend_r};
      endcase
    end
    // Error flags clear on control register read
    if (rd_in && addr_in == SCRX_ADDR_CR) begin
      cr_nxt[SCRX_CR_OVERRUN_FLAG] = 1'b0;
      cr_nxt[SCRX_CR_PARITY_ERROR_FLAG] = 1'b0;
      cr_nxt[SCRX_CR_FRAMING_FLAG] = 1'b0;
    end
    if (buf_rd) begin
      pend_nxt = 1'b0;
      full_nxt = 1'b0;
    end
    if (wr_in) begin
      case (addr_in)
        SCRX_ADDR_MOD: mod_nxt = wdata_in;
        SCRX_ADDR_CR: begin
          cr_nxt[SCRX_CR_IOC] = wdata_in[SCRX_CR_IOC];
          cr_nxt[SCRX_CR_SCLKS] = wdata_in[SCRX_CR_SCLKS];
          cr_nxt[SCRX_CR_PE] = wdata_in[SCRX_CR_PE];
          cr_nxt[SCRX_CR_EVEN] = wdata_in[SCRX_CR_EVEN];
        end
        SCRX_ADDR_IRQ: div_nxt = {8'h00, wdata_in};
        default: begin
        end
      endcase
    end
    if (!receive_enable_bit) begin
      st_nxt = SCRX_IDLE;
      sclk_nxt = 1'b1;
    end else if (sm == SCRX_SM_IO) begin
      // Shift stage runs only while the receive flag is clear
      if (st_r != SCRX_SHIFT) begin
        st_nxt = SCRX_SHIFT;
        bit_nxt = 4'h0;
        sc_nxt = 8'h00;
        sclk_nxt = 1'b1;
      end else if (!pend_r && !ioc) begin
        sc_nxt = sc_r + 8'h01;
        if (sc_r == SCRX_SCLK_HALF) begin
          sc_nxt = 8'h00;
          sclk_nxt = !sclk_r;
          if (!sclk_r) begin
            sh_nxt = {1'b0, serial_in_pin_in, sh_r[7:1]};
            bit_nxt = bit_r + 4'h1;
          end
        end
      end else if (!pend_r && ioc && ext_edge) begin
        sh_nxt = {1'b0, serial_in_pin_in, sh_r[7:1]};
        bit_nxt = bit_r + 4'h1;
      end
      if (bit_r == 4'h8) begin
        bit_nxt = 4'h0;
        buf_nxt = sh_r[7:0];
        pend_nxt = 1'b1;
        sclk_nxt = 1'b1;
      end
    end else if (tick) begin
      case (st_r)
        SCRX_IDLE, SCRX_SHIFT: begin
          sclk_nxt = 1'b1;
          st_nxt = SCRX_IDLE;
          if (!serial_in_pin_in) begin
            st_nxt = SCRX_START;
            ph_nxt = 4'h0;
          end
        end
        SCRX_START: begin
          ph_nxt = ph_r + 4'h1;
          if (ph_r == SCRX_MID && serial_in_pin_in) begin
            st_nxt = SCRX_IDLE;
          end else if (ph_r == SCRX_MID) begin
            ph_nxt = 4'h0;
            bit_nxt = 4'h0;
            st_nxt = SCRX_DATA;
          end
        end
        SCRX_DATA: begin
          ph_nxt = ph_r + 4'h1;
          if (ph_r == 4'hf) begin
            sh_nxt = 9'h000;
            sh_nxt[bit_r] = serial_in_pin_in;
            sh_nxt = sh_nxt | sh_r;
            bit_nxt = bit_r + 4'h1;
            if (bit_r + 4'h1 == nbits) begin
              st_nxt = SCRX_STOP;
            end
          end
        end
        SCRX_STOP: begin
          ph_nxt = ph_r + 4'h1;
          if (ph_r >= 4'he) begin
            smp_nxt = {smp_r[1:0], serial_in_pin_in};
          end
          if (ph_r == 4'h1 || ph_r == 4'h2) begin
            smp_nxt = {smp_r[1:0], serial_in_pin_in};
          end
          if (ph_r == 4'h2) begin
            done = 1'b1;
            st_nxt = SCRX_IDLE;
          end
        end
        default: st_nxt = SCRX_IDLE;
      endcase
    end
    if (done) begin
      fr = sh_r;
      fer = !maj3({smp_r[1:0], serial_in_pin_in});
      case (sm)
        SCRX_SM_7B: begin
          dat = {1'b0, fr[6:0]};
          par = fr[7];
          parity_error_flag = pe && ((^fr[6:0]) ^ !even ^ par);
        end
        SCRX_SM_8B: begin
          dat = fr[7:0];
          par = fr[8];
          nin = fr[8];
          parity_error_flag = pe && ((^fr[7:0]) ^ !even ^ par);
        end
        default: begin
          dat = fr[7:0];
          nin = fr[8];
        end
      endcase
      raise = !(sm == SCRX_SM_9B && wu && !nin);
      if (raise) begin
        if (full_r && !buf_rd) begin
          cr_nxt[SCRX_CR_OVERRUN_FLAG] = 1'b1;
        end else begin
          buf_nxt = dat;
          full_nxt = 1'b1;
          pend_nxt = 1'b1;
          if (sm != SCRX_SM_7B || pe) begin
            cr_nxt[SCRX_CR_RB8] = pe ? par : nin;
          end
        end
        // Error flags set win over a same-cycle clear
        if (fer) begin
          cr_nxt[SCRX_CR_FRAMING_FLAG] = 1'b1;
        end
        if (parity_error_flag) begin
          cr_nxt[SCRX_CR_PARITY_ERROR_FLAG] = 1'b1;
        end
      end
      sh_nxt = 9'h000;
    end
    irq_nxt = pend_nxt && !pend_r;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mod_r <= SCRX_MOD_RST;
      cr_r <= SCRX_CR_RST;
      buf_r <= 8'h00;
      div_r <= SCRX_BAUD_DIV_RST;
      pend_r <= 1'b0;
      full_r <= 1'b0;
      st_r <= SCRX_IDLE;
      sh_r <= 9'h000;
      bit_r <= 4'h0;
      ph_r <= 4'h0;
      smp_r <= 3'h7;
      sc_r <= 8'h00;
      sclk_r <= 1'b1;
      ext_d_r <= 1'b1;
      rdata_out <= 8'h00;
      rx_interrupt_out <= 1'b0;
      shift_clock_pin_out <= 1'b1;
      shift_clock_pin_oe_out <= 1'b0;
      mode_out <= SCRX_MOD_RST;
    end else begin
      mod_r <= mod_nxt;
      cr_r <= cr_nxt;
      buf_r <= buf_nxt;
      div_r <= div_nxt;
      pend_r <= pend_nxt;
      full_r <= full_nxt;
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      ph_r <= ph_nxt;
      smp_r <= smp_nxt;
      sc_r <= sc_nxt;
      sclk_r <= sclk_nxt;
      ext_d_r <= shift_clock_pin_in;
      rdata_out <= rdata_nxt;
      rx_interrupt_out <= irq_nxt;
      shift_clock_pin_out <= sclk_nxt;
      shift_clock_pin_oe_out <= (mod_nxt[SCRX_MOD_SM_LO +: 2] == SCRX_SM_IO)
                                && !cr_nxt[SCRX_CR_IOC];
      mode_out <= mod_nxt;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_rxe_blocks: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !receive_enable_bit |=> !$rose(pend_r)) else $error("reception while disabled");
  a_no_shift_pend: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pend_r && sm == SCRX_SM_IO) |=> $stable(sh_r))
    else $error("shift while flag set");
  a_wakeup_block: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done && sm == SCRX_SM_9B && wu && !sh_r[8]) |=> !$rose(pend_r))
    else $error("wake-up frame raised");
  a_ovr_keeps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done && full_r && !buf_rd && raise) |=> $stable(buf_r))
    else $error("overrun overwrote buffer");
  a_irq_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(pend_r) |-> rx_interrupt_out) else $error("irq missing");
  a_sclk_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (sm == SCRX_SM_IO && !ioc && !wr_in) |=> shift_clock_pin_oe_out)
    else $error("shift clock not driven");
  a_no_par9: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sm == SCRX_SM_9B |-> !pe) else $error("parity in nine bit");
  a_wu_off_all: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done && sm == SCRX_SM_9B && !wu && !full_r) |=> pend_r)
    else $error("frame dropped");
  c_io_byte: cover property (@(posedge clk_in) sm == SCRX_SM_IO && $rose(pend_r));
  c_uart_frame: cover property (@(posedge clk_in) done && sm == SCRX_SM_8B);
  c_overrun: cover property (@(posedge clk_in) $rose(cr_r[SCRX_CR_OVERRUN_FLAG]));
endmodule
`default_nettype wire

// File: scrx_far.sv
// Far-side model: async transmitter and external shift register
`timescale 1ns/1ps
`default_nettype none
module scrx_far #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_in,
  input wire logic sclk_dev_in,
  output logic serial_out,
  output logic sclk_out
);
  initial begin
    serial_out = 1'b1;
    sclk_out = 1'b1;
  end
  // ****************************************************
  // Async frame: start, data LSB first, stop, idle high
  // ****************************************************
  task automatic send(input logic [8:0] bits, input int n,
                      input logic stop);
    int i;
    serial_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_in);
    for (i = 0; i < n; i++) begin
      serial_out <= bits[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    serial_out <= stop;
    repeat (BIT_CLKS) @(posedge clk_in);
    serial_out <= 1'b1;
  endtask
  // ****************************************************
  // Shift byte: new bit on each falling shift clock edge
  // ****************************************************
  task automatic shift(input logic [7:0] d, input logic ext,
                       output logic ok);
    int i;
    int w;
    logic last;
    ok = 1'b1;
    for (i = 0; i < 8; i++) begin
      if (ext) begin
        sclk_out <= 1'b0;
        serial_out <= d[i];
        repeat (5) @(posedge clk_in);
        sclk_out <= 1'b1;
        repeat (5) @(posedge clk_in);
      end else begin
        last = sclk_dev_in;
        @(posedge clk_in);
        #1;
        for (w = 0; w < 200 && !(last === 1'b1 && sclk_dev_in === 1'b0);
             w++) begin
          last = sclk_dev_in;
          @(posedge clk_in);
          #1;
        end
        if (w == 200) begin
          ok = 1'b0;
        end
        serial_out <= d[i];
      end
    end
    repeat (10) @(posedge clk_in);
    // Released line must not keep showing the last bit
    serial_out <= ~d[7];
  endtask
endmodule
`default_nettype wire

// File: scrx_top_tb.sv
// Self-checking testbench for the serial channel receiver
`timescale 1ns/1ps
`default_nettype none
module scrx_top_tb;
  import scrx_pkg::*;
  localparam int DIV = 0;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic serial;
  logic sclk_ext;
  logic sclk_out;
  logic oe;
  logic irq;
  logic [7:0] mode_out;
  int irq_cnt = 0;
  int err_total = 0;
  int n_compared = 0;
  logic [7:0] d;
  logic ok;
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end
  scrx_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .serial_in_pin_in(serial), .shift_clock_pin_in(sclk_ext),
    .shift_clock_pin_out(sclk_out), .shift_clock_pin_oe_out(oe),
    .rx_interrupt_out(irq), .mode_out(mode_out));
  scrx_far #(.BIT_CLKS(16 * (DIV + 1))) i_far (.clk_in(clk_in),
    .sclk_dev_in(sclk_out), .serial_out(serial), .sclk_out(sclk_ext));
  // ****************************************************
  // Helpers
  // ****************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Irq pulses seen since c0, bounded wait
  task automatic irq_since(input int c0, input logic exp);
    int i;
    for (i = 0; i < 64 && irq_cnt == c0; i++) @(posedge clk_in);
    chk({7'h00, irq_cnt != c0}, {7'h00, exp});
  endtask
  task automatic frame(input logic [8:0] b, input int n, input logic stop,
                       input logic exp);
    int c0;
    c0 = irq_cnt;
    i_far.send(b, n, stop);
    irq_since(c0, exp);
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    rd_reg(a, d);
    chk(d & m, exp);
  endtask
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    rd_chk(SCRX_ADDR_MOD, 8'hff, SCRX_MOD_RST);
    rd_chk(SCRX_ADDR_CR, 8'hff, SCRX_CR_RST);
    chk(mode_out, 8'h00);
    wr_reg(SCRX_ADDR_IRQ, DIV[7:0]);
  endtask
  task automatic t_enable();
    wr_reg(SCRX_ADDR_MOD, 8'h02);
    frame({1'b0, 8'ha5}, 8, 1'b1, 1'b0);
    wr_reg(SCRX_ADDR_MOD, 8'h22);
    frame({1'b0, 8'h3c}, 8, 1'b1, 1'b1);
    rd_chk(SCRX_ADDR_BUF, 8'hff, 8'h3c);
  endtask
  task automatic t_parity();
    wr_reg(SCRX_ADDR_CR, 8'h60);
    frame({1'b0, 8'ha5}, 9, 1'b1, 1'b1);
    rd_chk(SCRX_ADDR_CR, 8'h08, 8'h00);
    rd_chk(SCRX_ADDR_BUF, 8'hff, 8'ha5);
    frame({1'b1, 8'ha5}, 9, 1'b1, 1'b1);
    rd_chk(SCRX_ADDR_CR, 8'h08, 8'h08);
    rd_reg(SCRX_ADDR_BUF, d);
    wr_reg(SCRX_ADDR_CR, 8'h20);
    frame({1'b1, 8'ha5}, 9, 1'b1, 1'b1);
    rd_chk(SCRX_ADDR_CR, 8'h08, 8'h00);
    rd_reg(SCRX_ADDR_BUF, d);
    wr_reg(SCRX_ADDR_MOD, 8'h21);
    wr_reg(SCRX_ADDR_CR, 8'h60);
    frame({2'b01, 7'h55}, 8, 1'b1, 1'b1);
    rd_chk(SCRX_ADDR_CR, 8'h88, 8'h88);
    rd_chk(SCRX_ADDR_BUF, 8'h7f, 8'h55);
    wr_reg(SCRX_ADDR_CR, 8'h00);
    frame({2'b00, 7'h2a}, 7, 1'b1, 1'b1);
    rd_chk(SCRX_ADDR_CR, 8'h08, 8'h00);
    rd_chk(SCRX_ADDR_BUF, 8'h7f, 8'h2a);
  endtask
  task automatic t_wakeup();
    wr_reg(SCRX_ADDR_MOD, 8'h33);
    // Parity enable set but must be ignored in nine bit mode
    wr_reg(SCRX_ADDR_CR, 8'h20);
    frame({1'b0, 8'h11}, 9, 1'b1, 1'b0);
    frame({1'b1, 8'h42}, 9, 1'b1, 1'b1);
    rd_chk(SCRX_ADDR_CR, 8'h88, 8'h80);
    rd_chk(SCRX_ADDR_BUF, 8'hff, 8'h42);
    if (d === 8'h42) begin
      wr_reg(SCRX_ADDR_MOD, 8'h23);
    end
    frame({1'b0, 8'h99}, 9, 1'b1, 1'b1);
    rd_chk(SCRX_ADDR_CR, 8'h80, 8'h00);
    rd_chk(SCRX_ADDR_BUF, 8'hff, 8'h99);
    wr_reg(SCRX_ADDR_MOD, 8'ha3);
    rd_reg(SCRX_ADDR_MOD, d);
    chk(mode_out, 8'ha3);
  endtask
  task automatic t_errors();
    wr_reg(SCRX_ADDR_MOD, 8'h22);
    // Plain eight bit frames: parity left on would add a ninth bit
    wr_reg(SCRX_ADDR_CR, 8'h00);
    frame({1'b0, 8'h81}, 8, 1'b1, 1'b1);
    i_far.send({1'b0, 8'h7e}, 8, 1'b1);
    repeat (20) @(posedge clk_in);
    rd_chk(SCRX_ADDR_CR, 8'h10, 8'h10);
    rd_chk(SCRX_ADDR_BUF, 8'hff, 8'h81);
    i_far.send({1'b0, 8'h5a}, 8, 1'b0);
    repeat (20) @(posedge clk_in);
    rd_chk(SCRX_ADDR_CR, 8'h04, 8'h04);
    rd_reg(SCRX_ADDR_BUF, d);
  endtask
  task automatic t_shift();
    int c0;
    int i;
    int falls;
    wr_reg(SCRX_ADDR_MOD, 8'h20);
    c0 = irq_cnt;
    i_far.shift(8'hc3, 1'b0, ok);
    chk({7'h00, oe}, 8'h01);
    chk({7'h00, ok}, 8'h01);
    irq_since(c0, 1'b1);
    // Shift clock must stand still while the buffer is unread
    falls = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_in);
      #1;
      if (sclk_out !== 1'b1) begin
        falls++;
      end
    end
    chk(falls[7:0], 8'h00);
    wr_reg(SCRX_ADDR_CR, 8'h01);
    rd_chk(SCRX_ADDR_BUF, 8'hff, 8'hc3);
    chk({7'h00, oe}, 8'h00);
    c0 = irq_cnt;
    i_far.shift(8'h5a, 1'b1, ok);
    irq_since(c0, 1'b1);
    rd_chk(SCRX_ADDR_BUF, 8'hff, 8'h5a);
  endtask
  task automatic end_of_test();
    $display("Compared %0d values, %0d wrong", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_enable();
    t_parity();
    t_wakeup();
    t_errors();
    t_shift();
    end_of_test();
  end
endmodule
`default_nettype wire
